// ---- llcf_map.vh ----
`ifndef LLCF_MAP_VH
`define LLCF_MAP_VH

// register offsets on the host register port
`define LLCF_ADDR_LOOP_ADC      6'h10
`define LLCF_ADDR_OUT_POL       6'h13
`define LLCF_ADDR_REF_LOW       6'h14

// loop_and_adc_control field positions
`define LLCF_CURRENT_CTRL_BIT   0
`define LLCF_RES_DISC_BIT       2
`define LLCF_ADC_SRC_LSB        5
`define LLCF_ADC_SRC_MSB        7

// output_polarity_config field positions
`define LLCF_REF_HIGH_LSB       0
`define LLCF_REF_HIGH_MSB       1
`define LLCF_SHUNT_RANGE_BIT    2
`define LLCF_LOW_GATE_RANGE_BIT 4
`define LLCF_REF_SWAP_BIT       6
`define LLCF_POLARITY_BIT       7

// reset values
`define LLCF_RST_CURRENT_CTRL   1'h0
`define LLCF_RST_RES_DISC       1'h0
`define LLCF_RST_ADC_SRC        3'h0
`define LLCF_RST_SHUNT_RANGE    1'h0
`define LLCF_RST_LOW_GATE_RANGE 1'h0
`define LLCF_RST_REF_SWAP       1'h1
`define LLCF_RST_POLARITY       1'h0
`define LLCF_RST_REF_CODE       10'h000
`define LLCF_RST_RDATA          8'h00

// adc source codes
`define LLCF_ADC_VDD_DIV8       3'h0
`define LLCF_ADC_SUPPLY_DIV30   3'h1
`define LLCF_ADC_VB_DIV30       3'h2
`define LLCF_ADC_MONITOR_DIODE  3'h3
`define LLCF_ADC_SHUNT          3'h4
`define LLCF_ADC_LOW_GATE_DIV30 3'h5
`define LLCF_ADC_HIGH_GATE_DIV30 3'h6
`define LLCF_ADC_ANALOG_INPUT   3'h7

// reference code end points
`define LLCF_REF_CODE_MIN       10'h000
`define LLCF_REF_CODE_MAX       10'h3FF

`endif

// ---- llcf_config_regs.v ----
// Function
// - polarity select at output_polarity_config bit 7, reset 0; 0 N-type, 1 P-type laser.
// - resistor disconnect at loop_and_adc_control bit 2, reset 0; 1 uses external resistor.
// - ADC source select at loop_and_adc_control bits 7:5, reset 000, eight sources in order.
// - control mode bit 0 selects optical power control with diode feedback.
// - internal resistor follows 8-bit code, present only while disconnect is 0.
// - 10-bit reference from output_polarity_config bits 1:0 high and 0x14 low, reset zero.
// - code 000 gives minimum reference, 3FF maximum, logarithmic steps.
// - polarity 1 inserts level converter with 1:2 scaling into feedback, only while control mode bit is 0.
// - low gate range bit at output_polarity_config bit 4, reset 0; 1 reaches laser supply.
// - reference swap at output_polarity_config bit 6, reset 1; 0 inverts control polarity.
// - control mode bit at loop_and_adc_control bit 0, reset 0; 1 current control.
`timescale 1ns/10ps
`include "llcf_map.vh"

module llcf_config_regs
(
    input  wire       clock,                    // system clock, 100 MHz
    input  wire       resetn,                   // asynchronous reset, active low
    input  wire       reg_wr,                   // register write strobe
    input  wire       reg_rd,                   // register read strobe
    input  wire [5:0] reg_addr,                 // register address
    input  wire [7:0] reg_wdata,                // register write data
    output reg  [7:0] reg_rdata,                // register read data
    output reg        reg_rvalid,               // read data valid pulse
    input  wire [7:0] resistor_code,            // programmable resistor code
    output wire       laser_polarity_sel,       // 0 N-type, 1 P-type laser
    output wire       int_resistor_disconnect,  // 1 external monitor resistor
    output wire [2:0] adc_source_sel,           // ADC input multiplexer select
    output wire       current_control_sel,      // 1 current control mode
    output wire       apc_mode_en,              // optical power control active
    output wire       shunt_voltage_range,      // shunt voltage range select
    output wire       low_gate_range_sel,       // low side gate upper range
    output wire       reference_swap,           // 1 standard, 0 inverted control
    output wire [9:0] ref_code,                 // logarithmic reference code
    output wire       ref_at_min,               // reference at minimum code
    output wire       ref_at_max,               // reference at maximum code
    output wire       monitor_resistor_en,      // internal resistor switched in
    output wire [7:0] monitor_resistor_code,    // code applied to internal resistor
    output wire       level_conv_en             // 1:2 level converter in feedback
);

    reg       polarity_ff;
    reg       res_disc_ff;
    reg [2:0] adc_src_ff;
    reg       current_ctrl_ff;
    reg       shunt_range_ff;
    reg       low_gate_range_ff;
    reg       ref_swap_ff;
    reg [9:0] ref_code_ff;
    reg [7:0] nxt_rdata;

    wire wr_loop = reg_wr && (reg_addr == `LLCF_ADDR_LOOP_ADC);
    wire wr_pol  = reg_wr && (reg_addr == `LLCF_ADDR_OUT_POL);
    wire wr_ref  = reg_wr && (reg_addr == `LLCF_ADDR_REF_LOW);

    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            polarity_ff       <= `LLCF_RST_POLARITY;
            res_disc_ff       <= `LLCF_RST_RES_DISC;
            adc_src_ff        <= `LLCF_RST_ADC_SRC;
            current_ctrl_ff   <= `LLCF_RST_CURRENT_CTRL;
            shunt_range_ff    <= `LLCF_RST_SHUNT_RANGE;
            low_gate_range_ff <= `LLCF_RST_LOW_GATE_RANGE;
            ref_swap_ff       <= `LLCF_RST_REF_SWAP;
            ref_code_ff       <= `LLCF_RST_REF_CODE;
        end
        else
        begin
            if (wr_loop)
            begin
                current_ctrl_ff <= reg_wdata[`LLCF_CURRENT_CTRL_BIT];
                res_disc_ff     <= reg_wdata[`LLCF_RES_DISC_BIT];
                adc_src_ff      <= reg_wdata[`LLCF_ADC_SRC_MSB:`LLCF_ADC_SRC_LSB];
            end
            if (wr_pol)
            begin
                polarity_ff       <= reg_wdata[`LLCF_POLARITY_BIT];
                ref_swap_ff       <= reg_wdata[`LLCF_REF_SWAP_BIT];
                low_gate_range_ff <= reg_wdata[`LLCF_LOW_GATE_RANGE_BIT];
                shunt_range_ff    <= reg_wdata[`LLCF_SHUNT_RANGE_BIT];
                ref_code_ff[9:8]  <= reg_wdata[`LLCF_REF_HIGH_MSB:`LLCF_REF_HIGH_LSB];
            end
            if (wr_ref)
                ref_code_ff[7:0] <= reg_wdata;
        end
    end

    // read mux; unused bits and unmapped addresses read zero
    always @*
    begin
        nxt_rdata = 8'h00;
        case (reg_addr)
            `LLCF_ADDR_LOOP_ADC:
            begin
                nxt_rdata[`LLCF_ADC_SRC_MSB:`LLCF_ADC_SRC_LSB] = adc_src_ff;
                nxt_rdata[`LLCF_RES_DISC_BIT]     = res_disc_ff;
                nxt_rdata[`LLCF_CURRENT_CTRL_BIT] = current_ctrl_ff;
            end
            `LLCF_ADDR_OUT_POL:
            begin
                nxt_rdata[`LLCF_POLARITY_BIT]       = polarity_ff;
                nxt_rdata[`LLCF_REF_SWAP_BIT]       = ref_swap_ff;
                nxt_rdata[`LLCF_LOW_GATE_RANGE_BIT] = low_gate_range_ff;
                nxt_rdata[`LLCF_SHUNT_RANGE_BIT]    = shunt_range_ff;
                nxt_rdata[`LLCF_REF_HIGH_MSB:`LLCF_REF_HIGH_LSB] = ref_code_ff[9:8];
            end
            `LLCF_ADDR_REF_LOW:
                nxt_rdata = ref_code_ff[7:0];
            default:
                nxt_rdata = 8'h00;
        endcase
    end

    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            reg_rdata  <= `LLCF_RST_RDATA;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
                reg_rdata <= nxt_rdata;
        end
    end

    // analog controls from stored fields; monitor_resistor_code passes resistor_code while disconnect is 0
    assign laser_polarity_sel      = polarity_ff;
    assign int_resistor_disconnect = res_disc_ff;
    assign adc_source_sel          = adc_src_ff;
    assign current_control_sel     = current_ctrl_ff;
    assign apc_mode_en             = ~current_ctrl_ff;
    assign shunt_voltage_range     = shunt_range_ff;
    assign low_gate_range_sel      = low_gate_range_ff;
    assign reference_swap          = ref_swap_ff;
    assign ref_code                = ref_code_ff;
    assign ref_at_min              = (ref_code_ff == `LLCF_REF_CODE_MIN);
    assign ref_at_max              = (ref_code_ff == `LLCF_REF_CODE_MAX);
    assign monitor_resistor_en     = ~res_disc_ff;
    assign monitor_resistor_code   = res_disc_ff ? 8'h00 : resistor_code;
    // polarity is ignored in current control mode
    assign level_conv_en           = polarity_ff & ~current_ctrl_ff;

endmodule

// ---- llcf_loop_model.sv ----
`timescale 1ns/10ps
module llcf_loop_model
(
    input  wire       clock,         // system clock
    input  wire       resetn,        // reset, active low
    output reg  [7:0] resistor_code  // resistor code, new value every cycle
);
    always @(posedge clock or negedge resetn)
        if (!resetn)
            resistor_code <= 8'h5A;
        else
            resistor_code <= resistor_code + 8'h01;
endmodule

// ---- llcf_config_regs_assertions.sv ----
`timescale 1ns/10ps
module llcf_chk
(
    input wire       clock, resetn,                       // clock and reset
    input wire       reg_wr, reg_rd, reg_rvalid,          // port strobes
    input wire [5:0] reg_addr,                            // address
    input wire [7:0] reg_wdata,                           // write data
    input wire       laser_polarity_sel, reference_swap,  // fields
    input wire       apc_mode_en, current_control_sel,    // mode
    input wire       monitor_resistor_en,                 // resistor present
    input wire       int_resistor_disconnect,             // resistor off
    input wire       ref_at_min, level_conv_en,           // decodes
    input wire [9:0] ref_code                             // reference code
);
    reg [7:0] wd_q;
    always @(posedge clock)
        wd_q <= reg_wdata;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence s_wr_pol;
        reg_wr && reg_addr == 6'h13;
    endsequence
    sequence s_wr_low;
        reg_wr && reg_addr == 6'h14;
    endsequence
    a_read_answer: assert property (reg_rvalid == $past(reg_rd))
        else $error("read answer timing wrong");
    a_polarity_write: assert property (s_wr_pol |=> laser_polarity_sel == wd_q[7])
        else $error("polarity not stored");
    a_swap_write: assert property (s_wr_pol |=> reference_swap == wd_q[6])
        else $error("swap not stored");
    a_ref_low: assert property (s_wr_low |=> ref_code[7:0] == wd_q)
        else $error("reference low part not stored");
    a_apc_mode: assert property (apc_mode_en != current_control_sel)
        else $error("power control mode wrong");
    a_res_present: assert property (monitor_resistor_en != int_resistor_disconnect)
        else $error("internal resistor presence wrong");
    a_ref_min_flag: assert property (ref_at_min == (ref_code == 10'h000))
        else $error("minimum flag wrong");
    a_level_conv: assert property (level_conv_en == (laser_polarity_sel && !current_control_sel))
        else $error("level converter wrong");
endmodule
bind llcf_config_regs llcf_chk u_chk (.clock(clock), .resetn(resetn), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rvalid(reg_rvalid), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .laser_polarity_sel(laser_polarity_sel), .reference_swap(reference_swap),
    .apc_mode_en(apc_mode_en), .current_control_sel(current_control_sel),
    .monitor_resistor_en(monitor_resistor_en), .ref_at_min(ref_at_min),
    .int_resistor_disconnect(int_resistor_disconnect), .level_conv_en(level_conv_en),
    .ref_code(ref_code));

// ---- laser_loop_config_fields_test.sv ----
`timescale 1ns/10ps
module laser_loop_config_fields_test;
    reg        clock = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    reg  [5:0] reg_addr = 6'h00;
    reg  [7:0] reg_wdata = 8'h00;
    wire [7:0] reg_rdata, resistor_code, monitor_resistor_code;
    wire [2:0] adc_source_sel;
    wire [9:0] ref_code;
    wire       reg_rvalid, laser_polarity_sel, int_resistor_disconnect, current_control_sel;
    wire       apc_mode_en, shunt_voltage_range, low_gate_range_sel, reference_swap;
    wire       ref_at_min, ref_at_max, monitor_resistor_en, level_conv_en;
    integer    mismatches = 0, n_compared = 0, i;
    always #5 clock = ~clock;
    llcf_loop_model u_loop (.clock(clock), .resetn(resetn), .resistor_code(resistor_code));
    llcf_config_regs u_dut (.clock(clock), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .resistor_code(resistor_code),
        .laser_polarity_sel(laser_polarity_sel), .int_resistor_disconnect(int_resistor_disconnect),
        .adc_source_sel(adc_source_sel), .current_control_sel(current_control_sel),
        .apc_mode_en(apc_mode_en), .shunt_voltage_range(shunt_voltage_range),
        .low_gate_range_sel(low_gate_range_sel), .reference_swap(reference_swap),
        .ref_code(ref_code), .ref_at_min(ref_at_min), .ref_at_max(ref_at_max),
        .monitor_resistor_en(monitor_resistor_en), .level_conv_en(level_conv_en),
        .monitor_resistor_code(monitor_resistor_code));
    task chk(input string nm, input [9:0] seen, input [9:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp)
            begin
                mismatches = mismatches + 1;
                $display("ERROR %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task wr(input [5:0] a, input [7:0] d);
        begin
            @(posedge clock);
            reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
            @(posedge clock);
            reg_wr <= 1'b0;
            #1;
        end
    endtask
    task rd(input [5:0] a, input [7:0] e);
        begin
            @(posedge clock);
            reg_rd <= 1'b1; reg_addr <= a;
            @(posedge clock);
            reg_rd <= 1'b0;
            #1;
            chk("rvalid", reg_rvalid, 1'h1);
            chk("rdata", reg_rdata, e);
        end
    endtask
    task test_done;
        begin
            if (mismatches == 0 && n_compared > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    initial
    begin
        #100000;
        mismatches = mismatches + 1;
        test_done;
    end
    initial
    begin
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        #1;
        chk("swap_rst", reference_swap, 1'h1);
        chk("min_rst", ref_at_min, 1'h1);
        rd(6'h10, 8'h00);
        rd(6'h13, 8'h40);
        rd(6'h14, 8'h00);
        for (i = 0; i < 8; i = i + 1)
        begin
            wr(6'h10, {i[2:0], 5'h00});
            chk("adc_src", adc_source_sel, i[2:0]);
        end
        wr(6'h10, 8'hFF);
        rd(6'h10, 8'hE5);
        chk("apc", apc_mode_en, 1'h0);
        chk("cur_ctrl", current_control_sel, 1'h1);
        chk("disc", int_resistor_disconnect, 1'h1);
        chk("mres_en", monitor_resistor_en, 1'h0);
        chk("mres_code", monitor_resistor_code, 8'h00);
        wr(6'h10, 8'h00);
        chk("apc", apc_mode_en, 1'h1);
        chk("mres_en", monitor_resistor_en, 1'h1);
        chk("mres_code", monitor_resistor_code, resistor_code);
        wr(6'h13, 8'hFF);
        rd(6'h13, 8'hD7);
        chk("level_conv", level_conv_en, 1'h1);
        chk("gate_range", low_gate_range_sel, 1'h1);
        chk("shunt_range", shunt_voltage_range, 1'h1);
        chk("polarity", laser_polarity_sel, 1'h1);
        wr(6'h14, 8'hFF);
        chk("ref_code", ref_code, 10'h3FF);
        chk("ref_max", ref_at_max, 1'h1);
        wr(6'h20, 8'hFF);
        rd(6'h20, 8'h00);
        wr(6'h13, 8'h00);
        chk("ref_code", ref_code, 10'h0FF);
        chk("swap", reference_swap, 1'h0);
        chk("shunt_range", shunt_voltage_range, 1'h0);
        chk("ref_min", ref_at_min, 1'h0);
        chk("ref_max", ref_at_max, 1'h0);
        chk("level_conv", level_conv_en, 1'h0);
        test_done;
    end
endmodule
